// >>> hdl/scbd_defines.svh
// Constants for the command block decoder
`ifndef SCBD_DEFINES_SVH
`define SCBD_DEFINES_SVH
`define SCBD_OP_INIT 8'h00
`define SCBD_OP_TGT 8'h01
`define SCBD_OP_SG 8'h02
`define SCBD_OP_INIT_RES 8'h03
`define SCBD_OP_SG_RES 8'h04
`define SCBD_OP_BDR 8'h81
`define SCBD_ST_OK 8'h00
`define SCBD_ST_NOT_TGT 8'h1a
`define SCBD_ST_BAD_OP 8'h3f
`define SCBD_B_LEN_MSB 5'h04
`define SCBD_B_STATUS 5'h0e
`define SCBD_CAP_OP 3'h1
`define SCBD_CAP_ADDR 3'h2
`define SCBD_CAP_CDBL 3'h3
`define SCBD_CAP_LEN_MSB 3'h5
`define SCBD_CAP_LEN_MID 3'h6
`define SCBD_CAP_LEN_LSB 3'h7
`define SCBD_WLEN_LAST 3'h2
`define SCBD_ID_MSB 7
`define SCBD_ID_LSB 5
`define SCBD_DIR_MSB 4
`define SCBD_DIR_LSB 3
`define SCBD_LUN_MSB 2
`define SCBD_LUN_LSB 0
`define SCBD_DIR_CMD 2'b00
`define SCBD_DIR_IN 2'b01
`define SCBD_DIR_OUT 2'b10
`define SCBD_REG_CTRL 8'h00
`define SCBD_REG_STAT 8'h04
`define SCBD_REG_DEC 8'h08
`define SCBD_REG_LEN 8'h0c
`define SCBD_WIN_BIT 7
`define SCBD_CTRL_START 0
`define SCBD_CTRL_TGT 1
`define SCBD_STAT_DONE 1
`define SCBD_STAT_REJ 2
`endif

// >>> hdl/scbd_pkg.sv
// Types of the command block decoder
`include "scbd_defines.svh"
package scbd_pkg;
  typedef enum logic [2:0] {
    SCBD_K_INIT = 3'b000,
    SCBD_K_TGT = 3'b001,
    SCBD_K_SG = 3'b010,
    SCBD_K_INIT_RES = 3'b011,
    SCBD_K_SG_RES = 3'b100,
    SCBD_K_BDR = 3'b101,
    SCBD_K_BAD = 3'b111
  } scbd_kind_e;

  typedef enum logic [2:0] {
    SCBD_S_IDLE = 3'b000,
    SCBD_S_FETCH = 3'b001,
    SCBD_S_DECIDE = 3'b010,
    SCBD_S_WAIT = 3'b011,
    SCBD_S_WLEN = 3'b100,
    SCBD_S_WSTAT = 3'b101
  } scbd_state_e;

  typedef struct packed {
    scbd_kind_e kind;
    logic [2:0] id;
    logic id_is_init;
    logic [1:0] dir;
    logic len_check;
    logic [2:0] lun;
    logic sg;
    logic resid;
  } scbd_cmd_s;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] wdata;
  } scbd_mem_req_s;

  typedef struct packed {
    scbd_state_e st;
    logic [2:0] idx;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [23:0] len;
    logic [7:0] status;
    logic busy;
    logic done;
    logic rej;
    logic tgt_mode;
    logic ph;
    logic ack;
    logic [31:0] rdat;
    logic req;
    scbd_cmd_s cmd;
    logic [23:0] xlen;
  } scbd_regs_s;

  function automatic scbd_kind_e scbd_op_kind(input logic [7:0] op);
    case (op)
      `SCBD_OP_INIT: scbd_op_kind = SCBD_K_INIT;
      `SCBD_OP_TGT: scbd_op_kind = SCBD_K_TGT;
      `SCBD_OP_SG: scbd_op_kind = SCBD_K_SG;
      `SCBD_OP_INIT_RES: scbd_op_kind = SCBD_K_INIT_RES;
      `SCBD_OP_SG_RES: scbd_op_kind = SCBD_K_SG_RES;
      `SCBD_OP_BDR: scbd_op_kind = SCBD_K_BDR;
      default: scbd_op_kind = SCBD_K_BAD;
    endcase
  endfunction : scbd_op_kind
endpackage : scbd_pkg

// >>> hdl/scbd_ccb_mem.sv
// Byte store holding one command control block
`timescale 1ns/1ps
module scbd_ccb_mem
  import scbd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Access port
  input scbd_mem_req_s req,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [32];

  // No reset on the array; software fills it before start
  always_ff @(posedge core_clk)
  begin
    if (req.we)
    begin
      mem_q[req.addr] <= req.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= mem_q[req.addr];
    end
  end
endmodule : scbd_ccb_mem

// >>> hdl/scbd_decode.sv
// Registered decode of opcode and address/control byte
`timescale 1ns/1ps
`include "scbd_defines.svh"
module scbd_decode
  import scbd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Block bytes
  input wire logic [7:0] opcode,
  input wire logic [7:0] addr_byte,
  // Decoded command
  output scbd_cmd_s cmd
);
  scbd_cmd_s cmd_d;

  always_comb
  begin
    cmd_d.kind = scbd_op_kind(opcode);
    cmd_d.id = addr_byte[`SCBD_ID_MSB:`SCBD_ID_LSB];
    cmd_d.id_is_init = (cmd_d.kind == SCBD_K_TGT);
    cmd_d.dir = addr_byte[`SCBD_DIR_MSB:`SCBD_DIR_LSB];
    // Direction table applies to every kind except target blocks
    cmd_d.len_check = (cmd_d.kind != SCBD_K_TGT) &&
      (cmd_d.dir == `SCBD_DIR_IN || cmd_d.dir == `SCBD_DIR_OUT);
    cmd_d.lun = addr_byte[`SCBD_LUN_MSB:`SCBD_LUN_LSB];
    cmd_d.sg = (cmd_d.kind == SCBD_K_SG) || (cmd_d.kind == SCBD_K_SG_RES);
    cmd_d.resid = (cmd_d.kind == SCBD_K_INIT_RES) || (cmd_d.kind == SCBD_K_SG_RES);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cmd <= '{kind: SCBD_K_INIT, default: '0};
    end
    else
    begin
      cmd <= cmd_d;
    end
  end
endmodule : scbd_decode

// >>> hdl/scbd_top.sv
// Command control block decoder with Wishbone register slave
`timescale 1ns/1ps
`include "scbd_defines.svh"
module scbd_top
  import scbd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [3:0] wb_sel,
  input wire logic [7:0] wb_adr,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // SCSI engine request
  output logic scsi_req,
  output scbd_cmd_s scsi_cmd,
  output logic [23:0] scsi_len,
  output logic [7:0] scsi_cdb_len,
  // SCSI engine completion
  input wire logic scsi_done,
  input wire logic [23:0] scsi_resid
);
  scbd_regs_s q;
  scbd_regs_s d;
  scbd_mem_req_s mreq;
  logic [7:0] mdata;
  scbd_cmd_s dec;
  logic bus_go;
  logic win;

  scbd_ccb_mem u_mem (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .req(mreq),
    .rdata(mdata)
  );

  scbd_decode u_dec (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .opcode(q.b0),
    .addr_byte(q.b1),
    .cmd(dec)
  );

  assign bus_go = wb_cyc && wb_stb && !q.ack;
  assign win = wb_adr[`SCBD_WIN_BIT];

  always_comb
  begin
    d = q;
    d.req = 1'b0;
    d.ack = 1'b0;
    mreq.we = 1'b0;
    mreq.wdata = 8'h00;
    mreq.addr = q.busy ? 5'h00 : wb_adr[6:2];
    // Bus: phase 0 addresses, phase 1 answers; block window waits while busy
    if (bus_go && !q.ph && !(win && q.busy))
    begin
      d.ph = 1'b1;
    end
    if (q.ph)
    begin
      d.ph = 1'b0;
      d.ack = 1'b1;
      d.rdat = 32'h0000_0000;
      if (win)
      begin
        d.rdat = {24'h00_0000, mdata};
        mreq.we = wb_we && wb_sel[0];
        mreq.wdata = wb_dat_w[7:0];
      end
      else
      begin
        case (wb_adr)
          `SCBD_REG_CTRL:
          begin
            d.rdat = {30'h0, q.tgt_mode, 1'b0};
            if (wb_we && wb_sel[0])
            begin
              d.tgt_mode = wb_dat_w[`SCBD_CTRL_TGT];
              // Start while busy is ignored
              if (wb_dat_w[`SCBD_CTRL_START] && !q.busy)
              begin
                d.busy = 1'b1;
                d.st = SCBD_S_FETCH;
                d.idx = 3'h0;
              end
            end
          end
          `SCBD_REG_STAT:
          begin
            d.rdat = {16'h0000, q.status, 5'h00, q.rej, q.done, q.busy};
            if (wb_we && wb_sel[0])
            begin
              if (wb_dat_w[`SCBD_STAT_DONE])
              begin
                d.done = 1'b0;
              end
              if (wb_dat_w[`SCBD_STAT_REJ])
              begin
                d.rej = 1'b0;
              end
            end
          end
          `SCBD_REG_DEC:
            d.rdat = {16'h0000, 1'b0, dec.resid, dec.sg, dec.len_check, 1'b0, dec.kind, q.b1};
          `SCBD_REG_LEN:
            d.rdat = {8'h00, q.len};
          default:
            d.rdat = 32'h0000_0000;
        endcase
      end
    end
    // Sequencer; its flag sets come after the clears so a set wins
    unique case (q.st)
      SCBD_S_IDLE:
      begin
      end
      SCBD_S_FETCH:
      begin
        mreq.addr = {2'b00, q.idx};
        d.idx = q.idx + 3'h1;
        unique case (q.idx)
          `SCBD_CAP_OP: d.b0 = mdata;
          `SCBD_CAP_ADDR: d.b1 = mdata;
          `SCBD_CAP_LEN_MSB: d.len[23:16] = mdata;
          `SCBD_CAP_LEN_MID: d.len[15:8] = mdata;
          `SCBD_CAP_LEN_LSB:
          begin
            d.len[7:0] = mdata;
            d.st = SCBD_S_DECIDE;
          end
          default:
          begin
          end
        endcase
        if (q.idx == `SCBD_CAP_CDBL)
        begin
          if (dec.kind == SCBD_K_BDR)
          begin
            d.len = 24'h00_0000;
            d.b2 = 8'h00;
            d.st = SCBD_S_DECIDE;
          end
          else
          begin
            d.b2 = mdata;
          end
        end
      end
      SCBD_S_DECIDE:
      begin
        if (dec.kind == SCBD_K_BAD)
        begin
          d.status = `SCBD_ST_BAD_OP;
          d.rej = 1'b1;
          d.st = SCBD_S_WSTAT;
        end
        else if (dec.kind == SCBD_K_TGT && !q.tgt_mode)
        begin
          d.status = `SCBD_ST_NOT_TGT;
          d.rej = 1'b1;
          d.st = SCBD_S_WSTAT;
        end
        else
        begin
          // Kinds 00/02/03/04/81, and 01 in target mode, hand the decoded block to the engine
          d.req = 1'b1;
          d.cmd = dec;
          d.xlen = q.len;
          d.st = SCBD_S_WAIT;
        end
      end
      SCBD_S_WAIT:
      begin
        if (scsi_done)
        begin
          d.status = `SCBD_ST_OK;
          d.idx = 3'h0;
          if (q.cmd.resid)
          begin
            d.len = scsi_resid;
            d.st = SCBD_S_WLEN;
          end
          else
          begin
            d.st = SCBD_S_WSTAT;
          end
        end
      end
      SCBD_S_WLEN:
      begin
        mreq.we = 1'b1;
        mreq.addr = `SCBD_B_LEN_MSB + {2'b00, q.idx};
        unique case (q.idx)
          3'h0: mreq.wdata = q.len[23:16];
          3'h1: mreq.wdata = q.len[15:8];
          default: mreq.wdata = q.len[7:0];
        endcase
        d.idx = q.idx + 3'h1;
        if (q.idx == `SCBD_WLEN_LAST)
        begin
          d.st = SCBD_S_WSTAT;
        end
      end
      SCBD_S_WSTAT:
      begin
        mreq.we = 1'b1;
        mreq.addr = `SCBD_B_STATUS;
        mreq.wdata = q.status;
        d.busy = 1'b0;
        d.done = 1'b1;
        d.st = SCBD_S_IDLE;
      end
      default:
      begin
        d.st = SCBD_S_IDLE;
        d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '{st: SCBD_S_IDLE, cmd: '{kind: SCBD_K_INIT, default: '0}, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign wb_ack = q.ack;
  assign wb_dat_r = q.rdat;
  assign scsi_req = q.req;
  assign scsi_cmd = q.cmd;
  assign scsi_len = q.xlen;
  assign scsi_cdb_len = q.b2;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_init_issue: assert property (
    q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_INIT |=> scsi_req && !scsi_cmd.sg && !scsi_cmd.resid)
    else $error("initiator block not issued");
  a_tgt_serve: assert property (
    q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_TGT && q.tgt_mode |=> scsi_req && scsi_cmd.id_is_init)
    else $error("target block not served");
  a_tgt_reject: assert property (
    q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_TGT && !q.tgt_mode
      |=> !scsi_req && q.status == `SCBD_ST_NOT_TGT && mreq.we && mreq.addr == `SCBD_B_STATUS)
    else $error("target block without target mode not refused");
  a_sg_issue: assert property (
    q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_SG |=> scsi_req && scsi_cmd.sg)
    else $error("scatter-gather block not issued");
  a_resid_wback: assert property (
    q.st == SCBD_S_WAIT && scsi_done && q.cmd.resid
      |=> mreq.we && mreq.addr == `SCBD_B_LEN_MSB ##1 mreq.we ##1 mreq.we ##1 q.st == SCBD_S_WSTAT)
    else $error("length rewrite missing");
  a_bdr_issue: assert property (
    q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_BDR |=> scsi_req && scsi_cmd.kind == SCBD_K_BDR)
    else $error("bus device reset not issued");
  a_bdr_skip: assert property (
    q.st == SCBD_S_FETCH && q.idx == `SCBD_CAP_CDBL && dec.kind == SCBD_K_BDR
      |=> q.st == SCBD_S_DECIDE && q.b2 == 8'h00 && q.len == 24'h00_0000)
    else $error("bytes after address read for bus device reset");
  a_id_lun: assert property (
    scsi_req |-> scsi_cmd.id == q.b1[`SCBD_ID_MSB:`SCBD_ID_LSB] && scsi_cmd.lun == q.b1[`SCBD_LUN_MSB:`SCBD_LUN_LSB])
    else $error("ID or LUN field wrong");
  a_dir_check: assert property (
    scsi_req && !scsi_cmd.id_is_init |-> scsi_cmd.dir == q.b1[`SCBD_DIR_MSB:`SCBD_DIR_LSB] &&
      scsi_cmd.len_check == (scsi_cmd.dir == `SCBD_DIR_IN || scsi_cmd.dir == `SCBD_DIR_OUT))
    else $error("length check does not follow direction");
  a_len_order: assert property (
    q.st == SCBD_S_FETCH && q.idx == `SCBD_CAP_LEN_LSB |=> q.len[7:0] == $past(mdata) && q.st == SCBD_S_DECIDE)
    else $error("length low byte not taken last");
  a_bad_op: assert property (
    q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_BAD |=> !scsi_req && q.status == `SCBD_ST_BAD_OP && q.rej)
    else $error("unknown opcode not refused");

  c_bdr: cover property (q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_BDR);
  c_tgt_rej: cover property (q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_TGT && !q.tgt_mode);
  c_resid: cover property (q.st == SCBD_S_WLEN ##3 q.st == SCBD_S_IDLE);
  c_bad: cover property (q.st == SCBD_S_DECIDE && dec.kind == SCBD_K_BAD);
endmodule : scbd_top

// >>> sim/scbd_engine_model.sv
// Behavioural SCSI engine answering decoded block requests
`timescale 1ns/1ps
module scbd_engine_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Request from decoder and bench knobs
  input wire logic scsi_req,
  input wire logic [3:0] lat,
  input wire logic [23:0] resid_val,
  // Completion back to decoder
  output logic scsi_done,
  output logic [23:0] scsi_resid
);
  initial
  begin
    scsi_done = 1'b0;
    scsi_resid = 24'h000000;
  end
  // Residual shows inverted data outside the pulse so a stale sample is caught
  always @(posedge core_clk)
  begin
    if (scsi_req === 1'b1 && sys_rst === 1'b0)
    begin
      repeat (lat) @(posedge core_clk);
      scsi_done <= 1'b1;
      scsi_resid <= resid_val;
      @(posedge core_clk);
      scsi_done <= 1'b0;
      scsi_resid <= ~resid_val;
    end
  end
endmodule : scbd_engine_model

// >>> sim/tb.sv
// Self-checking bench for the command block decoder
`timescale 1ns/1ps
`include "scbd_defines.svh"
module tb
  import scbd_pkg::*;
;
  logic core_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, scsi_req, scsi_done;
  logic [3:0] wb_sel, lat;
  logic [7:0] wb_adr, scsi_cdb_len;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [23:0] scsi_len, scsi_resid, resid_val;
  scbd_cmd_s scsi_cmd;
  int n_fail, cmp_count, n_req, r0;
  logic [7:0] st;

  scbd_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_sel(wb_sel), .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .scsi_req(scsi_req), .scsi_cmd(scsi_cmd), .scsi_len(scsi_len), .scsi_cdb_len(scsi_cdb_len),
    .scsi_done(scsi_done), .scsi_resid(scsi_resid));
  scbd_engine_model i_eng (.core_clk(core_clk), .sys_rst(sys_rst), .scsi_req(scsi_req), .lat(lat),
    .resid_val(resid_val), .scsi_done(scsi_done), .scsi_resid(scsi_resid));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Request pulses last one cycle, so count them at every edge
  always @(posedge core_clk)
  begin
    if (scsi_req === 1'b1)
      n_req++;
  end

  task automatic complete_run;
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
    end
    while (wb_ack !== 1'b1 && t < 300);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (t >= 300)
      chk(32'h0, 32'h1);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb_xfer(1'b0, a, 32'h0, q);
  endtask : rd

  // Builds a block, starts it, waits for done and returns the status byte
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [23:0] len, input logic tgt,
    output logic [7:0] s, output logic rej);
    logic [31:0] q;
    int t;
    r0 = n_req;
    wr(8'h80, {24'h0, op});
    wr(8'h84, {24'h0, b1});
    wr(8'h88, 32'h6);
    wr(8'h90, {24'h0, len[23:16]});
    wr(8'h94, {24'h0, len[15:8]});
    wr(8'h98, {24'h0, len[7:0]});
    wr(`SCBD_REG_CTRL, {30'h0, tgt, 1'b1});
    t = 0;
    do
    begin
      rd(`SCBD_REG_STAT, q);
      t++;
    end
    while (q[`SCBD_STAT_DONE] !== 1'b1 && t < 100);
    chk({30'h0, q[`SCBD_STAT_DONE], q[0]}, 32'h2);
    s = q[15:8];
    rej = q[`SCBD_STAT_REJ];
    wr(`SCBD_REG_STAT, 32'h6);
  endtask : run

  task automatic t_init;
    logic r;
    logic [31:0] q;
    run(8'h00, {3'd5, 2'b01, 3'd3}, 24'h012345, 1'b0, st, r);
    rd(`SCBD_REG_DEC, q);
    chk(q, 32'h0000_10ab);
    chk(st, 32'h0);
    chk(n_req - r0, 1);
    chk(32'(scsi_cmd.kind), 32'(SCBD_K_INIT));
    chk(scsi_cmd.id, 5);
    chk({scsi_cmd.dir, scsi_cmd.len_check}, 32'h3);
    chk(scsi_cmd.lun, 3);
    chk(scsi_len, 32'h012345);
    chk(scsi_cdb_len, 6);
    run(8'h00, {3'd1, 2'b00, 3'd7}, 24'hfffffe, 1'b0, st, r);
    chk({scsi_cmd.dir, scsi_cmd.len_check}, 32'h0);
    chk(scsi_len, 32'hfffffe);
  endtask : t_init

  task automatic t_tgt;
    logic r;
    logic [31:0] q;
    run(8'h01, {3'd2, 5'h0}, 24'h10, 1'b0, st, r);
    chk(st, 32'h1a);
    chk(n_req - r0, 0);
    chk(r, 1);
    rd(8'hb8, q);
    chk(q, 32'h1a);
    run(8'h01, {3'd2, 5'h0}, 24'h10, 1'b1, st, r);
    chk(32'(scsi_cmd.kind), 32'(SCBD_K_TGT));
    rd(`SCBD_REG_CTRL, q);
    chk(q, 32'h2);
    chk({scsi_cmd.id, scsi_cmd.id_is_init}, 32'h5);
    wr(`SCBD_REG_CTRL, 32'h0);
  endtask : t_tgt

  task automatic t_sg;
    logic r;
    run(8'h02, {3'd6, 2'b10, 3'd0}, 24'h000200, 1'b0, st, r);
    chk(32'(scsi_cmd.kind), 32'(SCBD_K_SG));
    chk({scsi_cmd.sg, scsi_cmd.resid}, 32'h2);
    chk({scsi_cmd.dir, scsi_cmd.len_check}, 32'h5);
  endtask : t_sg

  task automatic t_resid(input logic [7:0] op, input logic [3:0] l, input logic [23:0] rv);
    logic r;
    logic [31:0] q;
    lat <= l;
    resid_val <= rv;
    run(op, 8'h20, 24'h00ffff, 1'b0, st, r);
    chk(32'(scsi_cmd.kind), (op == 8'h03) ? 32'(SCBD_K_INIT_RES) : 32'(SCBD_K_SG_RES));
    chk({scsi_cmd.sg, scsi_cmd.resid}, (op == 8'h03) ? 32'h1 : 32'h3);
    chk(scsi_len, 32'h00ffff);
    chk(st, 32'h0);
    rd(8'h90, q);
    chk(q, rv[23:16]);
    rd(8'h94, q);
    chk(q, rv[15:8]);
    rd(8'h98, q);
    chk(q, rv[7:0]);
    rd(`SCBD_REG_LEN, q);
    chk(q, rv);
  endtask : t_resid

  task automatic t_bdr;
    logic r;
    run(8'h81, {3'd4, 5'h1f}, 24'habcdef, 1'b0, st, r);
    chk(32'(scsi_cmd.kind), 32'(SCBD_K_BDR));
    chk(scsi_cmd.id, 4);
    chk({scsi_len, scsi_cdb_len}, 32'h0);
    chk(st, 32'h0);
  endtask : t_bdr

  task automatic t_bad;
    logic r;
    logic [31:0] q;
    run(8'h55, 8'h00, 24'h1, 1'b0, st, r);
    chk(st, 32'h3f);
    chk(r, 1);
    chk(n_req - r0, 0);
    rd(8'h40, q);
    chk(q, 32'h0);
  endtask : t_bad

  initial
  begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
    wb_sel = 4'hf;
    lat = 4'h3;
    resid_val = 24'h0;
    n_fail = 0;
    cmp_count = 0;
    n_req = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_init;
    t_tgt;
    t_sg;
    t_resid(8'h03, 4'h9, 24'h000a0b);
    t_resid(8'h04, 4'h0, 24'h010203);
    t_bdr;
    t_bad;
    complete_run;
  end

  // A full run takes a few hundred cycles, far below the 20000-cycle limit
  initial
  begin
    #(50 * 20000);
    n_fail++;
    complete_run;
  end
endmodule : tb
